// [bench/nsbg_generator_test.sv]
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("wrong value at %0t: %s", $time, msg); \
        end \
    end

module nsbg_generator_test;
    // A 5 MHz setting makes one clock one reference tick, so a 20 ms data bit fits a short run.
    localparam int GEN_HZ = 5_000_000;
    localparam int MS     = GEN_HZ / 1000;

    logic core_clk, srst, even_sec_strobe, leap_strobe, src_bit, src_take;
    logic mod_bit, chip_bit, nav_bit, code_epoch, string_start, tm_active;
    int   err_total;
    int   checks;

    nsbg_generator #(.CLK_HZ(GEN_HZ)) nsbg_generator_i (
        .core_clk(core_clk), .srst(srst), .even_sec_strobe(even_sec_strobe),
        .leap_strobe(leap_strobe), .src_bit(src_bit), .src_take(src_take),
        .mod_bit(mod_bit), .chip_bit(chip_bit), .nav_bit(nav_bit),
        .code_epoch(code_epoch), .string_start(string_start), .tm_active(tm_active)
    );

    nsbg_nav_source nsbg_nav_source_i (
        .core_clk(core_clk), .srst(srst), .src_take(src_take), .src_bit(src_bit)
    );

    // Free-running clock at 25 ns.
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Inputs change and outputs are sampled at the falling edge, away from updates.
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // One-cycle epoch pulse; returns in the first cycle that shows the new string,
    // one edge after the strobe is taken.
    task automatic strobe(input logic leap);
        @(negedge core_clk);
        even_sec_strobe = ~leap;
        leap_strobe = leap;
        @(negedge core_clk);
        even_sec_strobe = 1'b0;
        leap_strobe = 1'b0;
        @(negedge core_clk);
    endtask

    // Outputs stay quiet in reset and the first chip after release is high.
    task automatic test_reset;
        step(6);
        `CHK(mod_bit | chip_bit | nav_bit | code_epoch | string_start, 1'b0, "active in reset")
        `CHK(tm_active | src_take, 1'b0, "level active in reset")
        srst = 1'b0;
        step(2);
        `CHK(chip_bit, 1'b1, "first chip after release")
        `CHK(string_start, 1'b0, "pulse at release")
        $display("test reset done");
    endtask

    // Both epoch sources restart the string with the same aligned boundary.
    task automatic test_epoch(input logic leap);
        strobe(leap);
        `CHK(string_start, 1'b1, "string start missing")
        `CHK(code_epoch, 1'b1, "code epoch not aligned")
        `CHK(chip_bit, 1'b1, "first chip not one")
        `CHK(nav_bit, 1'b0, "idle bit not zero")
        `CHK(mod_bit, 1'b1, "modulo-2 sum wrong")
        `CHK(tm_active, 1'b0, "mark active at start")
        step(1);
        `CHK(string_start, 1'b0, "start pulse too long")
        $display("test epoch done, leap %0b", leap);
    endtask

    // Chips are sampled mid-chip so the 9 or 10 tick jitter cannot move the result.
    task automatic test_code;
        int         t;
        int         target;
        int         ones;
        logic [9:0] head0;
        logic [9:0] head1;
        strobe(1'b0);
        t = 0;
        ones = 0;
        for (int k = 0; k < 521; k++) begin
            target = (k / 511) * MS + (2 * (k % 511) + 1) * MS / 1022;
            step(target - t);
            t = target;
            `CHK(mod_bit, chip_bit ^ nav_bit, "modulo-2 sum wrong")
            `CHK(nav_bit, 1'b0, "idle bit not zero")
            if (k < 511) ones += int'(chip_bit);
            if (k < 10) head0[9 - k] = chip_bit;
            if (k >= 511) head1[520 - k] = chip_bit;
            if (k == 510) begin
                step(MS - t);
                t = MS;
                `CHK(code_epoch, 1'b1, "period not one millisecond")
            end
        end
        // Read at stage seven, the all-ones load shows seven ones of its run, then zeros.
        `CHK(head0, 10'h3F8, "period head pattern")
        `CHK(head1, 10'h3F8, "second period head pattern")
        `CHK(ones, 256, "not a maximal-length sequence")
        $display("test code done");
    endtask

    // Idle bit with its meander halves, then the first requested data bit.
    task automatic test_data;
        int t;
        int epochs;
        strobe(1'b0);
        t = 0;
        epochs = 0;
        while (t < 21 * MS && src_take !== 1'b1) begin
            step(1);
            t++;
            if (code_epoch === 1'b1) epochs++;
            if (t == 5 * MS) `CHK(nav_bit, 1'b0, "meander not low first")
            if (t == 15 * MS) `CHK(nav_bit, 1'b1, "meander not high second")
        end
        `CHK(src_take, 1'b1, "no data request")
        `CHK(epochs, 19, "request not at 20 ms")
        step(1);
        `CHK(src_take, 1'b0, "request too long")
        step(1);
        `CHK(code_epoch, 1'b1, "bit edge off code epoch")
        `CHK(nav_bit, 1'b1, "relative code wrong")
        `CHK(mod_bit, ~chip_bit, "modulo-2 sum wrong")
        $display("test data done");
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence; every wait above is bounded, so this always reaches the verdict.
    initial begin
        srst = 1'b1;
        even_sec_strobe = 1'b0;
        leap_strobe = 1'b0;
        err_total = 0;
        checks = 0;
        test_reset;
        test_epoch(1'b0);
        test_epoch(1'b1);
        test_code;
        test_data;
        close_out;
    end
endmodule

// [bench/nsbg_nav_source.sv]
`timescale 1ns/1ps
// Stand-in for the upstream message source that feeds raw navigation bits.
module nsbg_nav_source #(
    parameter logic [7:0] PATTERN = 8'hB5
) (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic srst,
    // Request and data.
    input  wire logic src_take,
    output logic      src_bit
);
    logic [2:0] idx;
    logic       scramble;

    // The index moves only on a consumed bit; between takes the line wanders.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            idx      <= 3'h0;
            scramble <= 1'b0;
        end else begin
            scramble <= ~scramble;
            if (src_take) begin
                idx <= idx + 3'h1;
            end
        end
    end

    // raw source bits.
    // Stale data is never held, so a block that samples off its take cycle is caught.
    assign src_bit = src_take ? PATTERN[idx] : scramble;
endmodule

// [pkg/nsbg_pkg.sv]
package nsbg_pkg;

    // Clock and reference oscillator rates.
    localparam int CLK_HZ          = 40_000_000;
    localparam int CLK_PERIOD_PS   = 25_000;
    localparam int REF_HZ          = 5_000_000;

    // Spreading code rate and period.
    localparam int CHIP_RATE_HZ    = 511_000;
    localparam int CODE_PERIOD_US  = 1_000;
    localparam int REF_PER_CODE    = REF_HZ / 1_000_000 * CODE_PERIOD_US;
    localparam int CHIPS_PER_CODE  = CHIP_RATE_HZ / 1_000_000 * CODE_PERIOD_US + 
                                     (CHIP_RATE_HZ % 1_000_000) * CODE_PERIOD_US / 1_000_000;

    // String layout in milliseconds and bits.
    localparam int STRING_MS       = 2000;
    localparam int DATA_MS         = 1700;
    localparam int TM_MS           = 300;
    localparam int DATA_BIT_MS     = 20;
    localparam int MEANDER_MS      = 10;
    localparam int TM_BIT_MS       = 10;
    localparam int DATA_BITS       = 85;
    localparam int TM_BITS         = 30;

    // Time mark pattern, first transmitted bit in the top position.
    localparam logic [29:0] TM_PATTERN = 30'h3E375096;

    // Spreading register shape.
    localparam int LFSR_LEN        = 9;
    localparam int LFSR_TAP_A      = 5;
    localparam int LFSR_TAP_B      = 9;
    localparam int LFSR_OUT_STAGE  = 7;
    localparam logic [8:0] LFSR_INIT = 9'h1FF;

    // Reset values of the timing state.
    localparam logic [12:0] ACC_RESET = 13'h0000;

endpackage

// [rtl/nsbg_generator.sv]
`timescale 1ns/1ps
// Summary of operation
// - The spreading code comes from a 9-stage shift register with feedback 1 + x^5 + x^9.
// - Each code period starts with the register loaded to all ones.
// - The chip output is taken from stage seven, not the last stage.
// - Chips run at 511 per millisecond and the code repeats every millisecond.
// - The first chip of each period starts the 1111111000 run and recurs every millisecond.
// - The modulating bit is spreading chip xor navigation message, plus the 100 Hz meander in the data part only.
// - A 2 s string holds 85 data bits in 1.7 s, then the time mark in 0.3 s.
// - Data bits last 20 ms in relative code and are xored with 10 ms meander bits.
// - The time mark is the fixed 30-bit pattern, each bit lasting 10 ms.
// - The first data bit of every string is forced to zero.
// - String, bit, meander and mark edges coincide with a code period start, which is also a chip edge.
// - The last time mark bit ends on an even second of the onboard day.
// - A leap second correction moves the time mark onto the corrected two-second epochs.
// - All timing comes coherently from one reference oscillator.
// - The reference oscillator runs nominally at 5.0 MHz.
module nsbg_generator #(
    parameter int CLK_HZ = nsbg_pkg::CLK_HZ
) (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic srst,
    // Epoch strobes from the onboard timekeeping logic.
    input  wire logic even_sec_strobe,
    input  wire logic leap_strobe,
    // Navigation data source.
    input  wire logic src_bit,
    output logic      src_take,
    // Baseband outputs.
    output logic      mod_bit,
    output logic      chip_bit,
    output logic      nav_bit,
    output logic      code_epoch,
    output logic      string_start,
    output logic      tm_active
);

    localparam int          REF_DIV   = CLK_HZ / nsbg_pkg::REF_HZ;
    localparam logic [2:0]  REF_LAST  = 3'(REF_DIV - 1);
    localparam logic [13:0] CHIP_STEP = 14'(nsbg_pkg::CHIPS_PER_CODE);
    localparam logic [13:0] ACC_MOD   = 14'(nsbg_pkg::REF_PER_CODE);
    localparam logic [8:0]  CHIP_LAST = 9'(nsbg_pkg::CHIPS_PER_CODE - 1);
    localparam logic [10:0] MS_LAST   = 11'(nsbg_pkg::STRING_MS / nsbg_pkg::CODE_PERIOD_US
                                            * 1000 - 1);
    localparam logic [10:0] DATA_LAST = 11'(nsbg_pkg::DATA_MS - 1);
    localparam logic [4:0]  DBIT_LAST = 5'(nsbg_pkg::DATA_BIT_MS - 1);
    localparam logic [4:0]  TBIT_LAST = 5'(nsbg_pkg::TM_BIT_MS - 1);
    localparam logic [4:0]  MEANDER_H = 5'(nsbg_pkg::MEANDER_MS);
    localparam logic [4:0]  TM_TOP    = 5'(nsbg_pkg::TM_BITS - 1);

    // the clock must divide evenly down to the reference rate.
    if (CLK_HZ % nsbg_pkg::REF_HZ != 0 || REF_DIV < 1 || REF_DIV > 8) begin : g_chk
        $error("nsbg_generator: clock must be 1 to 8 times the reference rate");
    end

    logic [2:0]  ref_cnt;
    logic [12:0] acc;
    logic [8:0]  chip_cnt;
    logic [10:0] ms_cnt;
    logic [4:0]  slot_ms;
    logic [6:0]  slot_idx;
    logic        coded;
    logic        in_tm;
    logic        resync;
    logic        ref_tick;
    logic        chip_en;
    logic        ms_tick;
    logic        string_end;
    logic        data_bit_start;
    logic [13:0] next_acc;
    logic [8:0]  lfsr_state;
    logic        lfsr_chip;
    logic        meander;
    logic        next_nav;
    logic        epoch_q;
    logic        start_q;

    // a leap second realignment restarts the string just like an even second epoch.
    assign resync = even_sec_strobe | leap_strobe;
    assign in_tm  = (ms_cnt > DATA_LAST);

    // one divider and one accumulator feed every rate from the same clock.
    always_comb begin
        ref_tick   = (ref_cnt == REF_LAST);
        next_acc   = {1'b0, acc} + CHIP_STEP;
        chip_en    = ref_tick && (next_acc >= ACC_MOD);
        ms_tick    = chip_en && (chip_cnt == CHIP_LAST);
        string_end = ms_tick && (ms_cnt == MS_LAST);
    end

    // 20 ms data bits, the idle one opened at the string end, the rest on a code period end inside the data part.
    assign data_bit_start = string_end ||
                            (ms_tick && !in_tm && slot_ms == DBIT_LAST && ms_cnt != DATA_LAST);
    // the source is asked for its bit at each data bit after the idle one.
    assign src_take = data_bit_start && !string_end && !resync;

    // reference oscillator tick from the clock divider.
    always_ff @(posedge core_clk) begin
        if (srst || resync || ref_tick) begin
            ref_cnt <= 3'h0;
        end else begin
            ref_cnt <= ref_cnt + 3'h1;
        end
    end

    // 511 chips per 5000 reference ticks, exactly one code period per millisecond.
    always_ff @(posedge core_clk) begin
        if (srst || resync) begin
            acc      <= nsbg_pkg::ACC_RESET;
            chip_cnt <= 9'h000;
        end else if (ref_tick) begin
            acc      <= chip_en ? 13'(next_acc - ACC_MOD) : next_acc[12:0];
            if (chip_en) begin
                chip_cnt <= (chip_cnt == CHIP_LAST) ? 9'h000 : chip_cnt + 9'h001;
            end
        end
    end

    // millisecond position within the string, split into data and mark slots.
    // the string restarts on the even second, so the last mark bit ends there.
    always_ff @(posedge core_clk) begin
        if (srst || resync) begin
            ms_cnt   <= 11'h000;
            slot_ms  <= 5'h00;
            slot_idx <= 7'h00;
        end else if (ms_tick) begin
            ms_cnt <= string_end ? 11'h000 : ms_cnt + 11'h001;
            if (string_end || ms_cnt == DATA_LAST) begin
                slot_ms  <= 5'h00;
                slot_idx <= 7'h00;
            end else if (slot_ms == (in_tm ? TBIT_LAST : DBIT_LAST)) begin
                slot_ms  <= 5'h00;
                slot_idx <= slot_idx + 7'h01;
            end else begin
                slot_ms <= slot_ms + 5'h01;
            end
        end
    end

    // relative coding against the last coded bit.
    always_ff @(posedge core_clk) begin
        if (srst || resync || string_end) begin
            coded <= 1'b0;
        end else if (data_bit_start) begin
            coded <= src_bit ^ coded;
        end
    end

    // the reload opens each period on the ones run.
    // chips restart together with every other boundary.
    nsbg_lfsr u_lfsr (
        .core_clk (core_clk),
        .srst     (srst),
        .load     (ms_tick || resync),
        .shift    (chip_en),
        .state    (lfsr_state),
        .chip     (lfsr_chip)
    );

    // meander low in the first half of each data bit, high in the second.
    // the time mark replaces data and meander in the last 0.3 s.
    always_comb begin
        meander  = (slot_ms >= MEANDER_H);
        next_nav = in_tm ? nsbg_pkg::TM_PATTERN[TM_TOP - slot_idx[4:0]] : (coded ^ meander);
    end

    // one output stage keeps every output on the same edge.
    // The markers pass an extra stage, since the state they announce is itself one cycle
    // behind the event; without it they would lead the first chip by one cycle.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mod_bit      <= 1'b0;
            chip_bit     <= 1'b0;
            nav_bit      <= 1'b0;
            epoch_q      <= 1'b0;
            start_q      <= 1'b0;
            code_epoch   <= 1'b0;
            string_start <= 1'b0;
            tm_active    <= 1'b0;
        end else begin
            mod_bit      <= lfsr_chip ^ next_nav;
            chip_bit     <= lfsr_chip;
            nav_bit      <= next_nav;
            epoch_q      <= ms_tick || resync;
            start_q      <= string_end || resync;
            code_epoch   <= epoch_q;
            string_start <= start_q;
            tm_active    <= in_tm;
        end
    end

    // Helper: cycles since the last code epoch, for the period check.
    logic [15:0] period_cyc;
    always_ff @(posedge core_clk) begin
        if (srst || resync || ms_tick) begin
            period_cyc <= 16'h0000;
        end else begin
            period_cyc <= period_cyc + 16'h0001;
        end
    end

    a_code_period: assert property (@(posedge core_clk) disable iff (srst || resync)
        ms_tick |-> (period_cyc == 16'(CLK_HZ / 1000 - 1)))
        else $error("code period is not one millisecond");

    a_chip_tap: assert property (@(posedge core_clk) disable iff (srst)
        !$past(srst) |-> (chip_bit == $past(lfsr_state[6])))
        else $error("chip not taken from stage seven");

    a_epoch_ones: assert property (@(posedge core_clk) disable iff (srst)
        code_epoch |-> (lfsr_state == 9'h1FF) && lfsr_chip)
        else $error("code period does not open on the ones run");

    a_mod_xor: assert property (@(posedge core_clk) disable iff (srst)
        mod_bit == (chip_bit ^ nav_bit))
        else $error("modulating bit is not the xor of its parts");

    a_data_length: assert property (@(posedge core_clk) disable iff (srst || resync)
        (ms_tick && ms_cnt == DATA_LAST) |=> in_tm ##1 tm_active)
        else $error("time mark does not follow 1.7 s of data");

    a_meander_flip: assert property (@(posedge core_clk) disable iff (srst || resync)
        (ms_tick && !in_tm && slot_ms == 5'h09) |=> ##1 (nav_bit != $past(nav_bit, 2)))
        else $error("meander did not flip at the bit midpoint");

    a_tm_first: assert property (@(posedge core_clk) disable iff (srst || resync)
        (ms_tick && ms_cnt == DATA_LAST) |=> ##1 nav_bit && tm_active)
        else $error("time mark does not open with a one");

    a_idle_bit: assert property (@(posedge core_clk) disable iff (srst || resync)
        string_end |=> !coded ##1 (!nav_bit && string_start))
        else $error("first data bit of the string is not zero");

    a_rel_code: assert property (@(posedge core_clk) disable iff (srst)
        src_take |=> coded == ($past(src_bit) ^ $past(coded)))
        else $error("relative coding wrong");

    a_align_restart: assert property (@(posedge core_clk) disable iff (srst)
        resync |=> ((ms_cnt == 11'h000) && (chip_cnt == 9'h000) && (acc == 13'h0000))
        ##1 string_start)
        else $error("strings not restarted on the epoch strobe");

    c_string_end: cover property (@(posedge core_clk) disable iff (srst) string_end);
    c_src_take:   cover property (@(posedge core_clk) disable iff (srst) src_take);
    c_leap:       cover property (@(posedge core_clk) disable iff (srst) leap_strobe ##2 string_start);
    c_tm_entry:   cover property (@(posedge core_clk) disable iff (srst) $rose(tm_active));

endmodule

// [rtl/nsbg_lfsr.sv]
`timescale 1ns/1ps
module nsbg_lfsr #(
    parameter int         LEN       = nsbg_pkg::LFSR_LEN,
    parameter int         TAP_A     = nsbg_pkg::LFSR_TAP_A,
    parameter int         TAP_B     = nsbg_pkg::LFSR_TAP_B,
    parameter int         OUT_STAGE = nsbg_pkg::LFSR_OUT_STAGE,
    parameter logic [8:0] INIT      = nsbg_pkg::LFSR_INIT
) (
    // Clock and reset.
    input  wire logic           core_clk,
    input  wire logic           srst,
    // Control.
    input  wire logic           load,
    input  wire logic           shift,
    // State and chip.
    output logic [LEN-1:0]      state,
    output logic                chip
);

    // The tap and output stages must lie inside the register.
    if (LEN != 9 || TAP_A >= TAP_B || TAP_B != LEN || OUT_STAGE > LEN || OUT_STAGE < 1) begin : g_chk
        $error("nsbg_lfsr: unsupported register shape");
    end

    // reload all ones.
    // Stage one sits in bit 0; a shift moves every stage one place toward the last.
    always_ff @(posedge core_clk) begin
        if (srst || load) begin
            state <= INIT;
        end else if (shift) begin
            state <= {state[LEN-2:0], state[TAP_A-1] ^ state[TAP_B-1]};
        end
    end

    assign chip = state[OUT_STAGE-1];

    a_lfsr_feedback: assert property (@(posedge core_clk) disable iff (srst)
        (shift && !load) |=> (state[0] == ($past(state[TAP_A-1]) ^ $past(state[TAP_B-1])))
        && (state[LEN-1:1] == $past(state[LEN-2:0])))
        else $error("spreading register feedback wrong");

    a_lfsr_reload: assert property (@(posedge core_clk) disable iff (srst)
        load |=> (state == INIT) && chip)
        else $error("spreading register not reloaded");

endmodule
